// >>> npic_pkg.sv
// constants and states of the nested interrupt controller
// assumes one 100 MHz core clock and an apb register port of 8 address bits
`default_nettype none
package npic_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] A_LEVEL = 8'h00;
   localparam logic [7:0] A_PRIO0 = 8'h04;
   localparam logic [7:0] A_PRIO3 = 8'h10;
   localparam logic [7:0] A_PEND = 8'h14;
   localparam logic [7:0] A_EXTCFG = 8'h18;
   localparam logic [7:0] A_STAT = 8'h1C;
   // ---------------------------------------------------------------
   // fields and reset values
   // ---------------------------------------------------------------
   localparam int CC_HI_POS = 5;
   localparam int CC_LO_POS = 3;
   localparam int CFG_TLI_FALL = 8;
   localparam int CFG_EXT_FALL = 9;
   localparam logic [1:0] LVL_MAIN = 2'h2;
   localparam logic [1:0] LVL_ONE = 2'h1;
   localparam logic [1:0] LVL_TWO = 2'h0;
   localparam logic [1:0] LVL_OFF = 2'h3;
   localparam logic [7:0] PRIO_RST = 8'hFF;
   localparam logic [3:0] PRIO3_RO = 4'hF;
   localparam logic [9:0] EXTCFG_RST = 10'h000;
   localparam logic [2:0] RANK_TOP = 3'h4;
   // ---------------------------------------------------------------
   // vector region and numbering
   // ---------------------------------------------------------------
   localparam logic [15:0] VEC_TOP = 16'hFFFE;
   localparam logic [15:0] VEC_LOW = 16'hFFE0;
   localparam logic [3:0] VN_RESET = 4'h0;
   localparam logic [3:0] VN_TRAP = 4'h1;
   localparam logic [3:0] VN_MASK0 = 4'h2;
   // ---------------------------------------------------------------
   // sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RST = 4'h1,
      ST_IDLE = 4'h2,
      ST_STACK = 4'h4,
      ST_PC = 4'h8
   } npic_state_e;
endpackage : npic_pkg
`default_nettype wire

// >>> npic_top.sv
// nested priority interrupt controller: latching, arbitration, core entry
// assumes core handshakes are synchronous to clk, apb master on same clock
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`default_nettype none
module npic_top #(
   parameter int NUM_GRP = 4,
   parameter int GRP_PINS = 2,
   parameter int EXT_BASE = 2,
   parameter logic [13:0] HALT_CAP = 14'h003F
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tli_pin,
   input wire logic [NUM_GRP*GRP_PINS-1:0] ext_pin,
   input wire logic [13:1] periph_flag,
   input wire logic [13:1] periph_en,
   input wire logic [13:1] periph_clr,
   input wire logic core_instr_end,
   input wire logic core_trap,
   input wire logic core_return_from_interrupt,
   input wire logic [1:0] core_return_from_interrupt_level,
   input wire logic core_wait,
   input wire logic core_halt,
   input wire logic core_stack_done,
   output logic irq_req,
   output logic [3:0] irq_vec,
   output logic stack_req,
   output logic pc_load,
   output logic [15:0] vec_addr,
   output logic lvl_high,
   output logic lvl_low,
   output logic wake
);
   localparam int NV = 14;
   localparam int NP = NUM_GRP * GRP_PINS;

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (EXT_BASE < 1 || EXT_BASE + NUM_GRP > NV || NP > 8 || NP < 1) begin
      $error("npic_top: external groups do not fit the vector table");
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // level code to rank, main lowest, three highest
   function automatic logic [2:0] lvl_rank(input logic [1:0] code);
      case (code)
         npic_pkg::LVL_MAIN: lvl_rank = 3'h0;
         npic_pkg::LVL_ONE: lvl_rank = 3'h1;
         npic_pkg::LVL_TWO: lvl_rank = 3'h2;
         default: lvl_rank = 3'h3;
      endcase
   endfunction : lvl_rank

   // vector number to address, two bytes per vector downward
   function automatic logic [15:0] vec_of(input logic [3:0] vn);
      vec_of = npic_pkg::VEC_TOP - {11'h000, vn, 1'b0};
   endfunction : vec_of

   // field-wise merge that refuses the main level code
   function automatic logic [7:0] prio_merge(input logic [7:0] old_v,
                                             input logic [7:0] new_v);
      logic [7:0] r;
      r = old_v;
      for (int f = 0; f < 4; f++) begin
         if (new_v[2*f +: 2] != npic_pkg::LVL_MAIN) begin
            r[2*f +: 2] = new_v[2*f +: 2];
         end
      end
      prio_merge = r;
   endfunction : prio_merge

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_n;

   // two-stage release of the asynchronous reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ---------------------------------------------------------------
   // state declarations
   // ---------------------------------------------------------------
   npic_pkg::npic_state_e state_q;
   logic [3:0][7:0] prio_q;
   logic [1:0] level_q;
   logic [9:0] extcfg_q;
   logic [NV-1:0] edge_pend_q;
   logic [13:1] per_pend_q;
   logic [13:1] raw_q;
   logic [NP-1:0] pin_q;
   logic tli_q;
   logic trap_pend_q;
   logic [3:0] sel_q;
   logic [1:0] sel_lvl_q;
   logic [NV-1:0] req;
   logic [NV-1:0] edge_hit;
   logic [13:1] raw;
   logic win_valid;
   logic [3:0] win_idx;
   logic [2:0] cur_rank;
   logic take;
   logic accept;
   logic apb_done;
   logic apb_wr;
   logic [31:0] rd_mux;
   logic rd_err;

   // ---------------------------------------------------------------
   // apb slave
   // ---------------------------------------------------------------
   assign apb_done = psel & penable & pready;
   assign apb_wr = apb_done & pwrite & ~pslverr;

   // read mux and decode of mapped words
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b0;
      case (paddr)
         npic_pkg::A_LEVEL: begin
            rd_mux[npic_pkg::CC_HI_POS] = level_q[1];
            rd_mux[npic_pkg::CC_LO_POS] = level_q[0];
         end
         8'h04, 8'h08, 8'h0C, npic_pkg::A_PRIO3: begin
            rd_mux[7:0] = prio_q[paddr[3:2] - 2'h1];
         end
         npic_pkg::A_PEND: rd_mux[NV:0] = {trap_pend_q, req};
         npic_pkg::A_EXTCFG: rd_mux[9:0] = extcfg_q;
         npic_pkg::A_STAT: rd_mux[11:0] = {state_q, sel_q, win_idx};
         default: rd_err = 1'b1;
      endcase
   end

   // one wait state: answer on the second access cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         if (psel & penable & ~pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= rd_err;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // vector priority fields, upper half of the last word fixed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prio_q <= {4{npic_pkg::PRIO_RST}};
      end else if (apb_wr && paddr >= npic_pkg::A_PRIO0 &&
                   paddr <= npic_pkg::A_PRIO3) begin
         prio_q[paddr[3:2] - 2'h1] <=
            prio_merge(prio_q[paddr[3:2] - 2'h1], pwdata[7:0]);
         if (paddr == npic_pkg::A_PRIO3) begin
            prio_q[3][7:4] <= npic_pkg::PRIO3_RO;
         end
      end
   end

   // pin enables and edge selects
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         extcfg_q <= npic_pkg::EXTCFG_RST;
      end else if (apb_wr && paddr == npic_pkg::A_EXTCFG) begin
         extcfg_q <= pwdata[9:0];
      end
   end

   // ---------------------------------------------------------------
   // request capture
   // ---------------------------------------------------------------
   // edge detect on top pin and grouped external pins
   always_comb begin
      logic [NP-1:0] pe;
      pe = '0;
      edge_hit = '0;
      edge_hit[0] = extcfg_q[npic_pkg::CFG_TLI_FALL] ?
                    (tli_q & ~tli_pin) : (~tli_q & tli_pin);
      pe = (extcfg_q[npic_pkg::CFG_EXT_FALL] ? (pin_q & ~ext_pin) :
            (~pin_q & ext_pin)) & extcfg_q[NP-1:0];
      for (int g = 0; g < NUM_GRP; g++) begin
         edge_hit[EXT_BASE + g] = |pe[g*GRP_PINS +: GRP_PINS];
      end
   end

   // peripheral request is flag and enable together
   assign raw = periph_flag & periph_en;

   // input history for edge detection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tli_q <= 1'b0;
         pin_q <= '0;
         raw_q <= '0;
      end else begin
         tli_q <= tli_pin;
         pin_q <= ext_pin;
         raw_q <= raw;
      end
   end

   // edge latches, cleared on entry, a new edge wins over the clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         edge_pend_q <= '0;
      end else begin
         for (int i = 0; i < NV; i++) begin
            if (edge_hit[i]) begin
               edge_pend_q[i] <= 1'b1;
            end else if (accept && !trap_pend_q && win_idx == 4'(i)) begin
               edge_pend_q[i] <= 1'b0;
            end
         end
      end
   end

   // peripheral latches, dropped by the clear sequence or flag loss
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         per_pend_q <= '0;
      end else begin
         for (int i = 1; i < NV; i++) begin
            if (raw[i] && !raw_q[i]) begin
               per_pend_q[i] <= 1'b1;
            end else if (periph_clr[i] || !raw[i]) begin
               per_pend_q[i] <= 1'b0;
            end
         end
      end
   end

   // combined request per maskable vector
   assign req = edge_pend_q | {per_pend_q & raw, 1'b0};

   // trap request held until its entry starts
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trap_pend_q <= 1'b0;
      end else if (core_trap) begin
         trap_pend_q <= 1'b1;
      end else if (accept) begin
         trap_pend_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // arbitration
   // ---------------------------------------------------------------
   assign cur_rank = lvl_rank(level_q);

   // highest rank above current level, lower index wins ties
   always_comb begin
      logic [2:0] best;
      logic [2:0] rk;
      best = 3'h0;
      rk = 3'h0;
      win_valid = 1'b0;
      win_idx = 4'h0;
      for (int i = NV - 1; i >= 0; i--) begin
         rk = (i == 0) ? npic_pkg::RANK_TOP :
              lvl_rank(prio_q[i / 4][2*(i % 4) +: 2]);
         if (req[i] && (!core_halt || HALT_CAP[i]) &&
             rk > cur_rank && (!win_valid || rk >= best)) begin
            best = rk;
            win_idx = 4'(i);
            win_valid = 1'b1;
         end
      end
   end

   // trap outranks everything maskable; it is an executed instruction
   assign take = trap_pend_q | win_valid;
   assign accept = (state_q == npic_pkg::ST_IDLE) & core_instr_end & take;

   // winner presented to the core every cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_req <= 1'b0;
         irq_vec <= npic_pkg::VN_RESET;
         wake <= 1'b0;
      end else begin
         irq_req <= take;
         irq_vec <= trap_pend_q ? npic_pkg::VN_TRAP :
                    npic_pkg::VN_MASK0 + win_idx;
         wake <= (core_wait | core_halt) & take;
      end
   end

   // ---------------------------------------------------------------
   // entry sequencer
   // ---------------------------------------------------------------
   // reset entry, then stack, level, program counter per request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= npic_pkg::ST_RST;
         sel_q <= npic_pkg::VN_RESET;
         sel_lvl_q <= npic_pkg::LVL_OFF;
         stack_req <= 1'b0;
         pc_load <= 1'b0;
         vec_addr <= npic_pkg::VEC_TOP;
      end else begin
         pc_load <= 1'b0;
         case (state_q)
            npic_pkg::ST_RST: begin
               vec_addr <= vec_of(npic_pkg::VN_RESET);
               pc_load <= 1'b1;
               state_q <= npic_pkg::ST_IDLE;
            end
            npic_pkg::ST_IDLE: begin
               if (accept) begin
                  if (trap_pend_q) begin
                     sel_q <= npic_pkg::VN_TRAP;
                     sel_lvl_q <= npic_pkg::LVL_OFF;
                  end else begin
                     sel_q <= npic_pkg::VN_MASK0 + win_idx;
                     sel_lvl_q <= (win_idx == 4'h0) ? npic_pkg::LVL_OFF :
                        prio_q[win_idx[3:2]][{win_idx[1:0], 1'b0} +: 2];
                  end
                  stack_req <= 1'b1;
                  state_q <= npic_pkg::ST_STACK;
               end
            end
            npic_pkg::ST_STACK: begin
               if (core_stack_done) begin
                  stack_req <= 1'b0;
                  state_q <= npic_pkg::ST_PC;
               end
            end
            npic_pkg::ST_PC: begin
               vec_addr <= vec_of(sel_q);
               pc_load <= 1'b1;
               state_q <= npic_pkg::ST_IDLE;
            end
            default: begin
               stack_req <= 1'b0;
               state_q <= npic_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // current level
   // ---------------------------------------------------------------
   // entry load beats return, return beats a software write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level_q <= npic_pkg::LVL_OFF;
      end else if (state_q == npic_pkg::ST_STACK && core_stack_done) begin
         level_q <= sel_lvl_q;
      end else if (core_return_from_interrupt) begin
         level_q <= core_return_from_interrupt_level;
      end else if (apb_wr && paddr == npic_pkg::A_LEVEL) begin
         level_q <= {pwdata[npic_pkg::CC_HI_POS],
                     pwdata[npic_pkg::CC_LO_POS]};
      end
   end

   // level bits seen by the core as its condition code image
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lvl_high <= 1'b1;
         lvl_low <= 1'b1;
      end else begin
         lvl_high <= level_q[1];
         lvl_low <= level_q[0];
      end
   end
endmodule : npic_top
`default_nettype wire

// >>> npic_monitor.sv
// checker of the controller's entry, vector and wake outputs
// assumes it is bound to npic_top and sees only that module's ports
`default_nettype none
module npic_monitor (
   input wire logic clk,
   input wire logic nrst,
   input wire logic core_instr_end,
   input wire logic core_stack_done,
   input wire logic core_wait,
   input wire logic core_halt,
   input wire logic irq_req,
   input wire logic stack_req,
   input wire logic pc_load,
   input wire logic [15:0] vec_addr,
   input wire logic lvl_high,
   input wire logic lvl_low,
   input wire logic wake
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // sequences
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sequence s_done;
      stack_req && core_stack_done;
   endsequence
   sequence s_load;
      !stack_req ##1 pc_load ##1 !pc_load;
   endsequence
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   // stacking, then level, then a one-cycle vector load
   property p_load; s_done |=> s_load; endproperty
   a_load: assert property (p_load)
      else $error("vector load late after stacking");
   property p_pulse; pc_load |=> !pc_load; endproperty
   a_pulse: assert property (p_pulse)
      else $error("vector load longer than one cycle");
   property p_hold; stack_req && !core_stack_done |=> stack_req; endproperty
   a_hold: assert property (p_hold)
      else $error("stack request dropped early");
   property p_accept; $rose(stack_req) |-> $past(core_instr_end); endproperty
   a_accept: assert property (p_accept)
      else $error("entry started off an instruction boundary");
   property p_vec; pc_load |-> vec_addr >= 16'hFFE0 && !vec_addr[0]; endproperty
   a_vec: assert property (p_vec)
      else $error("vector outside the vector region");
   // reset, trap and top pin enter at level three
   property p_top; pc_load && vec_addr >= 16'hFFFA |=> lvl_high && lvl_low;
   endproperty
   a_top: assert property (p_top)
      else $error("top entry not at level three");
   property p_nomain; pc_load |=> !(lvl_high && !lvl_low); endproperty
   a_nomain: assert property (p_nomain)
      else $error("entry left level at main");
   property p_rst; pc_load && vec_addr == 16'hFFFE |-> !$past(stack_req);
   endproperty
   a_rst: assert property (p_rst)
      else $error("reset entry was stacked");
   property p_wake; $past(core_wait) && irq_req |-> wake; endproperty
   a_wake: assert property (p_wake)
      else $error("no wake from wait");
   property p_sleep; $past(!core_wait && !core_halt) |-> !wake; endproperty
   a_sleep: assert property (p_sleep)
      else $error("wake while running");
endmodule : npic_monitor
bind npic_top npic_monitor i_mon (.clk, .nrst, .core_instr_end,
   .core_stack_done, .core_wait, .core_halt, .irq_req, .stack_req,
   .pc_load, .vec_addr, .lvl_high, .lvl_low, .wake);
`default_nettype wire

// >>> npic_core_model.sv
// core model: instruction boundaries, context stack, trap and return
// assumes the controller's core-side ports on the same clock
`default_nettype none
module npic_core_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic run,
   input wire logic [3:0] dly,
   input wire logic do_trap,
   input wire logic do_return_from_interrupt,
   input wire logic stack_req,
   input wire logic pc_load,
   input wire logic [15:0] vec_addr,
   input wire logic lvl_high,
   input wire logic lvl_low,
   output logic core_instr_end,
   output logic core_stack_done,
   output logic core_trap,
   output logic core_return_from_interrupt,
   output logic [1:0] core_return_from_interrupt_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] stk_q [0:7];
   logic [2:0] sp_q;
   logic [3:0] cnt_q;
   logic in_tli_q;
   // all outputs change just after an edge; stacking takes dly plus one cycles
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         core_instr_end <= 1'b0;
         core_stack_done <= 1'b0;
         core_trap <= 1'b0;
         core_return_from_interrupt <= 1'b0;
         core_return_from_interrupt_level <= 2'h3;
         sp_q <= 3'h0;
         cnt_q <= 4'h0;
         in_tli_q <= 1'b0;
      end else begin
         core_instr_end <= run && !stack_req;
         core_stack_done <= 1'b0;
         core_trap <= do_trap && !in_tli_q;
         core_return_from_interrupt <= do_return_from_interrupt;
         if (stack_req && !core_stack_done) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q >= dly) begin
               core_stack_done <= 1'b1;
               cnt_q <= 4'h0;
               stk_q[sp_q] <= {lvl_high, lvl_low};
               sp_q <= sp_q + 3'h1;
            end
         end
         if (do_return_from_interrupt) begin
            core_return_from_interrupt_level <= stk_q[sp_q-3'h1];
            sp_q <= sp_q - 3'h1;
            in_tli_q <= 1'b0;
         end
         if (pc_load) begin
            in_tli_q <= (vec_addr == 16'hFFFA);
         end
      end
   end
endmodule : npic_core_model
`default_nettype wire

// >>> tb.sv
// testbench of the interrupt controller over apb and the core model
// assumes npic_top with default parameters and a 100 MHz clock
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, tli_pin, err;
   logic [7:0] paddr, ext_pin;
   logic [31:0] pwdata, prdata, rd;
   logic [13:1] periph_flag, periph_en, periph_clr;
   logic core_instr_end, core_trap, core_return_from_interrupt, core_wait, core_halt;
   logic core_stack_done, irq_req, stack_req, pc_load, lvl_high, lvl_low;
   logic wake, run, do_trap, do_return_from_interrupt;
   logic [1:0] core_return_from_interrupt_level;
   logic [3:0] irq_vec, dly;
   logic [15:0] vec_addr;
   logic [15:0] ev [3] = '{16'hFFF6, 16'hFFF2, 16'hFFF4};
   int ci [3] = '{2, 4, 3};
   int num_errors, checks_done;
   npic_top i_dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .tli_pin, .ext_pin, .periph_flag,
      .periph_en, .periph_clr, .core_instr_end, .core_trap, .core_return_from_interrupt,
      .core_return_from_interrupt_level, .core_wait, .core_halt, .core_stack_done, .irq_req,
      .irq_vec, .stack_req, .pc_load, .vec_addr, .lvl_high, .lvl_low, .wake);
   npic_core_model i_core (.clk, .nrst, .run, .dly, .do_trap, .do_return_from_interrupt,
      .stack_req, .pc_load, .vec_addr, .lvl_high, .lvl_low, .core_instr_end,
      .core_stack_done, .core_trap, .core_return_from_interrupt, .core_return_from_interrupt_level);
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   always #5 clk = ~clk;
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] s, e);
      checks_done++;
      if (s !== e) begin
         num_errors++;
         $display("unexpected %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task automatic guard(input logic ok);
      chk("handshake", 32'(ok), 32'h1);
      if (ok !== 1'b1) close_out();
   endtask : guard
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // one apb transfer: setup, access held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      guard(pready);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), rd, e);
   endtask : rdc
   // let the core run until the vector load, then compare it
   task automatic entry(input logic [15:0] e);
      int n;
      n = 0;
      run <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pc_load !== 1'b1 && n < 100);
      run <= 1'b0;
      guard(pc_load);
      chk("vector", 32'(vec_addr), 32'(e));
   endtask : entry
   task automatic pulse(input int k, input int i);
      if (k == 0) do_return_from_interrupt <= 1'b1;
      if (k == 1) do_trap <= 1'b1;
      if (k == 2) periph_clr[i] <= 1'b1;
      @(posedge clk);
      do_return_from_interrupt <= 1'b0;
      do_trap <= 1'b0;
      periph_clr <= '0;
      tick(3);
   endtask : pulse
   // ------------------------------------------------------------
   // sequence of tests
   // ------------------------------------------------------------
   initial begin
      {clk, nrst, psel, penable, pwrite, tli_pin, core_wait, core_halt} = '0;
      {run, do_trap, do_return_from_interrupt, paddr, ext_pin, pwdata, dly} = '0;
      {periph_flag, periph_en, periph_clr} = '0;
      tick(16);
      nrst <= 1'b1;
      tick(4);
      rdc(npic_pkg::A_LEVEL, 32'h28);
      rdc(npic_pkg::A_PRIO3, 32'hFF);
      rdc(8'h20, 32'h0);
      chk("slverr", 32'(err), 32'h1);
      apb(1'b1, npic_pkg::A_PRIO0, 32'hCF);
      apb(1'b1, npic_pkg::A_PRIO0, 32'h64);
      rdc(npic_pkg::A_PRIO0, 32'h44);
      apb(1'b1, npic_pkg::A_PRIO0 + 8'h04, 32'hFC);
      apb(1'b1, npic_pkg::A_LEVEL, 32'h20);
      rdc(npic_pkg::A_LEVEL, 32'h20);
      $display("test registers done");
      periph_flag[1] <= 1'b1;
      tick(4);
      rdc(npic_pkg::A_PEND, 32'h0);
      periph_en <= 13'h1FFF;
      tick(4);
      rdc(npic_pkg::A_PEND, 32'h2);
      entry(16'hFFF8);
      rdc(npic_pkg::A_LEVEL, 32'h08);
      chk("irq_req", 32'(irq_req), 32'h0);
      pulse(2, 1);
      rdc(npic_pkg::A_PEND, 32'h0);
      periph_flag[1] <= 1'b0;
      pulse(0, 0);
      rdc(npic_pkg::A_LEVEL, 32'h20);
      for (int k = 2; k < 5; k++) periph_flag[k] <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         dly <= 4'(k * 4);
         entry(ev[k]);
         pulse(2, ci[k]);
         pulse(0, 0);
      end
      periph_flag <= '0;
      $display("test peripheral and arbitration done");
      apb(1'b1, npic_pkg::A_LEVEL, 32'h28);
      pulse(1, 0);
      entry(16'hFFFC);
      tli_pin <= 1'b1;
      entry(16'hFFFA);
      pulse(0, 0);
      pulse(0, 0);
      rdc(npic_pkg::A_LEVEL, 32'h28);
      tli_pin <= 1'b0;
      apb(1'b1, npic_pkg::A_LEVEL, 32'h20);
      apb(1'b1, npic_pkg::A_EXTCFG, 32'h0C);
      ext_pin <= 8'h18;
      tick(4);
      rdc(npic_pkg::A_PEND, 32'h8);
      entry(16'hFFF4);
      rdc(npic_pkg::A_PEND, 32'h0);
      pulse(0, 0);
      ext_pin <= 8'h00;
      $display("test trap, top pin and external done");
      core_wait <= 1'b1;
      periph_flag[6] <= 1'b1;
      tick(4);
      chk("wake", 32'(wake), 32'h1);
      core_wait <= 1'b0;
      core_halt <= 1'b1;
      tick(4);
      chk("wake", 32'(wake), 32'h0);
      pulse(1, 0);
      chk("wake", 32'(wake), 32'h1);
      core_halt <= 1'b0;
      entry(16'hFFFC);
      pulse(2, 6);
      periph_flag[6] <= 1'b0;
      pulse(0, 0);
      $display("test wake done");
      close_out();
   end
endmodule : tb
`default_nettype wire
